// >>> etc_pkg.sv
package etc_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
	localparam logic [3:0] ADDR_EV_CTRL  = 4'h4;
	localparam logic [3:0] ADDR_INT_EN   = 4'h5;
	localparam logic [3:0] ADDR_INT_FLAG = 4'h6;
	localparam logic [3:0] ADDR_RUN_ST   = 4'h7;
	localparam logic [3:0] ADDR_DBG_CTRL = 4'h8;
	localparam logic [3:0] ADDR_LATCH    = 4'h9;
	localparam logic [3:0] ADDR_CNT_LO   = 4'hA;
	localparam logic [3:0] ADDR_CNT_HI   = 4'hB;
	localparam logic [3:0] ADDR_CMP_LO   = 4'hC;
	localparam logic [3:0] ADDR_CMP_HI   = 4'hD;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_ENABLE    = 0;
	localparam int BIT_CLK_LO    = 1;
	localparam int BIT_SYNC_RST  = 4;
	localparam int BIT_STBY_RUN  = 6;
	localparam int BIT_MODE_LO   = 0;
	localparam int BIT_OUT_EN    = 4;
	localparam int BIT_OUT_INIT  = 5;
	localparam int BIT_ASYNCHRONOUS_OUTPUT     = 6;
	localparam int BIT_EV_EN     = 0;
	localparam int BIT_EDGE      = 4;
	localparam int BIT_FILTER    = 6;
	localparam int BIT_CAPTURE_INTERRUPT      = 0;

	// ------------------------------------------------------------
	// reset values, masks, timing
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [7:0] MASK_CTRL_A   = 8'h57;
	localparam logic [7:0] MASK_CTRL_B   = 8'h77;
	localparam logic [7:0] MASK_EV_CTRL  = 8'h51;
	localparam logic [7:0] MASK_BIT0     = 8'h01;
	localparam int         FILTER_DEPTH  = 4;

	typedef enum logic [1:0] {
		PERIPHERAL_CLOCK  = 2'b00,
		CLK_HALF = 2'b01,
		CLK_COMP = 2'b10,
		CLK_RSVD = 2'b11
	} etc_clk_t;

	typedef enum logic [2:0] {
		M_PERIODIC = 3'b000,
		M_TIMEOUT  = 3'b001,
		M_CAPTURE  = 3'b010,
		M_FREQ     = 3'b011,
		M_PWIDTH   = 3'b100,
		M_FREQPW   = 3'b101,
		M_SINGLE   = 3'b110,
		M_PWM8     = 3'b111
	} etc_mode_t;

	typedef enum logic [1:0] {
		FP_IDLE = 2'b00,
		FP_HIGH = 2'b01,
		FP_LOW  = 2'b10
	} etc_fp_t;

endpackage : etc_pkg

// >>> etc_event_timer.sv
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module etc_event_timer
	import etc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       event_i,
	input  wire logic       comp_tick_i,
	input  wire logic       comp_restart_i,
	input  wire logic       standby_i,
	input  wire logic       debug_halt_i,
	output logic            out_o,
	output logic            irq_o,
	output logic            event_o
);

	logic [7:0]  ctrl_a_reg, ctrl_b_reg, ev_ctrl_reg, int_en_reg, dbg_reg, latch_reg;
	logic [15:0] cnt_reg, cmp_reg;
	logic        flag_reg, run_reg, out_reg, half_reg, ev_prev_reg, filt_reg;
	logic [2:0]  ev_sync_reg;
	logic [FILTER_DEPTH-1:0] hist_reg;
	etc_fp_t     fp_reg;
	etc_mode_t   mode;
	etc_clk_t    clk_sel;
	logic        tick, enabled, ev_clean, rise, fall, act, opp, capture_mode;
	logic        at_top, set_flag, do_cap, do_clr, do_stop, do_start;
	logic        wr_cnt_hi, wr_cmp_hi, rd_cmp_lo, pwm_out;

	assign mode    = etc_mode_t'(ctrl_b_reg[BIT_MODE_LO +: 3]);
	assign clk_sel = etc_clk_t'(ctrl_a_reg[BIT_CLK_LO +: 2]);
	assign capture_mode = (mode inside {M_CAPTURE, M_FREQ, M_PWIDTH, M_FREQPW});

	// ------------------------------------------------------------
	// enable, sleep and clock selection
	// ------------------------------------------------------------
	// standby run bit is moot on the companion clock, which follows its owner
	always_comb begin
		enabled = ctrl_a_reg[BIT_ENABLE];
		if (standby_i && !ctrl_a_reg[BIT_STBY_RUN] && clk_sel != CLK_COMP)
			enabled = 1'b0;
		if (debug_halt_i && !dbg_reg[BIT_CAPTURE_INTERRUPT])
			enabled = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			half_reg <= 1'b0;
		else
			half_reg <= ~half_reg;
	end

	always_comb begin
		unique case (clk_sel)
			PERIPHERAL_CLOCK:  tick = enabled;
			CLK_HALF: tick = enabled & half_reg;
			CLK_COMP: tick = enabled & comp_tick_i;
			CLK_RSVD: tick = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// event input: synchroniser, noise filter, edges
	// ------------------------------------------------------------
	// three stages; only stages two and three are looked at
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			ev_sync_reg <= 3'h0;
		else
			ev_sync_reg <= {ev_sync_reg[1:0], event_i};
	end

	// filter accepts a level only after four equal samples
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			hist_reg <= '0;
			filt_reg <= 1'b0;
		end else begin
			hist_reg <= {hist_reg[FILTER_DEPTH-2:0], ev_sync_reg[2]};
			if (&hist_reg)
				filt_reg <= 1'b1;
			else if (~|hist_reg)
				filt_reg <= 1'b0;
		end
	end

	always_comb begin
		if (ev_sync_reg[1] != ev_sync_reg[2])
			ev_clean = ev_prev_reg;
		else
			ev_clean = ev_sync_reg[2];
		if (ev_ctrl_reg[BIT_FILTER])
			ev_clean = filt_reg;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			ev_prev_reg <= 1'b0;
		else
			ev_prev_reg <= ev_clean;
	end

	// events gated by enable bits; debug halt also drops them
	assign rise = enabled & ev_ctrl_reg[BIT_EV_EN] & ev_clean & ~ev_prev_reg;
	assign fall = enabled & ev_ctrl_reg[BIT_EV_EN] & ~ev_clean & ev_prev_reg;
	assign act  = ev_ctrl_reg[BIT_EDGE] ? fall : rise;
	assign opp  = ev_ctrl_reg[BIT_EDGE] ? rise : fall;

	// ------------------------------------------------------------
	// mode decode of event actions
	// ------------------------------------------------------------
	assign at_top = (cnt_reg == cmp_reg);

	always_comb begin
		do_cap   = 1'b0;
		do_clr   = 1'b0;
		do_stop  = 1'b0;
		do_start = 1'b0;
		set_flag = 1'b0;
		unique case (mode)
			M_PERIODIC: set_flag = tick & at_top;
			M_TIMEOUT: begin
				do_start = act;
				do_stop  = opp;
				set_flag = tick & run_reg & at_top;
			end
			M_CAPTURE: begin
				do_cap   = act;
				set_flag = act;
			end
			M_FREQ: begin
				do_cap   = act;
				do_clr   = act;
				set_flag = act;
			end
			M_PWIDTH: begin
				do_clr   = act;
				do_cap   = opp;
				set_flag = opp;
			end
			M_FREQPW: begin
				do_clr   = act & (fp_reg == FP_IDLE);
				do_cap   = opp & (fp_reg == FP_HIGH);
				do_stop  = act & (fp_reg == FP_LOW);
				set_flag = do_stop;
			end
			M_SINGLE: begin
				do_start = (ev_ctrl_reg[BIT_EDGE] ? (rise | fall) : rise) & ~run_reg;
				set_flag = tick & run_reg & at_top;
			end
			M_PWM8: set_flag = tick & (cnt_reg[7:0] == cmp_reg[15:8]);
		endcase
	end

	// combined mode sequencer; a new run waits for the flag to be cleared
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			fp_reg <= FP_IDLE;
		else if (mode != M_FREQPW)
			fp_reg <= FP_IDLE;
		else begin
			unique case (fp_reg)
				FP_IDLE: if (do_clr && !flag_reg) fp_reg <= FP_HIGH;
				FP_HIGH: if (do_cap) fp_reg <= FP_LOW;
				FP_LOW:  if (do_stop) fp_reg <= FP_IDLE;
				default: fp_reg <= FP_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// counter and run state
	// ------------------------------------------------------------
	// software write has priority over counting
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			cnt_reg <= 16'h0000;
		else if (wr_i && addr_i == ADDR_CNT_HI)
			cnt_reg <= {wdata_i, latch_reg};
		else if (do_clr || do_start || (comp_restart_i && ctrl_a_reg[BIT_SYNC_RST]))
			cnt_reg <= 16'h0000;
		else if (tick && run_reg) begin
			if (mode == M_PWM8 && cnt_reg[7:0] >= cmp_reg[7:0])
				cnt_reg <= 16'h0000;
			else if ((mode == M_PERIODIC) && at_top)
				cnt_reg <= 16'h0000;
			else if (!((mode == M_SINGLE || mode == M_TIMEOUT) && at_top))
				cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	// single-shot and timeout stop at top; combined mode runs from clear to stop; others free-run while enabled
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			run_reg <= 1'b0;
		else if (!ctrl_a_reg[BIT_ENABLE])
			run_reg <= 1'b0;
		else if (do_start)
			run_reg <= 1'b1;
		else if (do_stop)
			run_reg <= 1'b0;
		else if ((mode == M_SINGLE || mode == M_TIMEOUT) && tick && at_top)
			run_reg <= 1'b0;
		else if (mode != M_SINGLE && mode != M_TIMEOUT && mode != M_FREQPW)
			run_reg <= 1'b1;
		else if (mode == M_FREQPW && do_clr)
			run_reg <= 1'b1;
	end

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	assign wr_cnt_hi = wr_i && addr_i == ADDR_CNT_HI;
	assign wr_cmp_hi = wr_i && addr_i == ADDR_CMP_HI;
	assign rd_cmp_lo = rd_i && addr_i == ADDR_CMP_LO;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ctrl_a_reg  <= RST_BYTE;
			ctrl_b_reg  <= RST_BYTE;
			ev_ctrl_reg <= RST_BYTE;
			int_en_reg  <= RST_BYTE;
			dbg_reg     <= RST_BYTE;
		end else if (wr_i) begin
			if (addr_i == ADDR_CTRL_A)   ctrl_a_reg  <= wdata_i & MASK_CTRL_A;
			if (addr_i == ADDR_CTRL_B)   ctrl_b_reg  <= wdata_i & MASK_CTRL_B;
			if (addr_i == ADDR_EV_CTRL)  ctrl_a_reg  <= ctrl_a_reg;
			if (addr_i == ADDR_EV_CTRL)  ev_ctrl_reg <= wdata_i & MASK_EV_CTRL;
			if (addr_i == ADDR_INT_EN)   int_en_reg  <= wdata_i & MASK_BIT0;
			if (addr_i == ADDR_DBG_CTRL) dbg_reg     <= wdata_i & MASK_BIT0;
		end
	end

	// shared latch: low write parks, high read fetches the held byte
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			latch_reg <= RST_BYTE;
		else if (wr_i && (addr_i == ADDR_LATCH || addr_i == ADDR_CNT_LO
		                  || addr_i == ADDR_CMP_LO))
			latch_reg <= wdata_i;
		else if (rd_i && addr_i == ADDR_CNT_LO)
			latch_reg <= cnt_reg[15:8];
		else if (rd_cmp_lo)
			latch_reg <= cmp_reg[15:8];
	end

	// compare doubles as top value or capture holder
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			cmp_reg <= 16'h0000;
		else if (wr_cmp_hi)
			cmp_reg <= {wdata_i, latch_reg};
		else if (do_cap && capture_mode)
			cmp_reg <= cnt_reg;
	end

	// set beats clear on the same cycle
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			flag_reg <= 1'b0;
		else if (set_flag)
			flag_reg <= 1'b1;
		else if (wr_i && addr_i == ADDR_INT_FLAG && wdata_i[BIT_CAPTURE_INTERRUPT])
			flag_reg <= 1'b0;
		else if (rd_cmp_lo && capture_mode)
			flag_reg <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			rdata_o <= RST_BYTE;
		else if (!rd_i)
			rdata_o <= RST_BYTE;
		else begin
			unique case (addr_i)
				ADDR_CTRL_A:   rdata_o <= ctrl_a_reg;
				ADDR_CTRL_B:   rdata_o <= ctrl_b_reg;
				ADDR_EV_CTRL:  rdata_o <= ev_ctrl_reg;
				ADDR_INT_EN:   rdata_o <= int_en_reg;
				ADDR_INT_FLAG: rdata_o <= {7'h00, flag_reg};
				ADDR_RUN_ST:   rdata_o <= {7'h00, run_reg};
				ADDR_DBG_CTRL: rdata_o <= dbg_reg;
				ADDR_LATCH:    rdata_o <= latch_reg;
				ADDR_CNT_LO:   rdata_o <= cnt_reg[7:0];
				ADDR_CMP_LO:   rdata_o <= cmp_reg[7:0];
				ADDR_CNT_HI,
				ADDR_CMP_HI:   rdata_o <= latch_reg;
				default:       rdata_o <= RST_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// output pin
	// ------------------------------------------------------------
	assign pwm_out = (cmp_reg[7:0] != 8'h00) && (cnt_reg[7:0] < cmp_reg[15:8]);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			out_reg <= 1'b0;
		else if (!ctrl_b_reg[BIT_OUT_EN])
			out_reg <= 1'b0;
		else if (mode == M_SINGLE) begin
			if (ctrl_b_reg[BIT_ASYNCHRONOUS_OUTPUT] && do_start)
				out_reg <= 1'b1;
			else
				out_reg <= run_reg;
		end else if (mode == M_PWM8)
			out_reg <= pwm_out;
		else
			out_reg <= ctrl_b_reg[BIT_OUT_INIT];
	end

	assign out_o   = out_reg;
	assign irq_o   = flag_reg & int_en_reg[BIT_CAPTURE_INTERRUPT];
	assign event_o = set_flag;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_out_forced_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!ctrl_b_reg[BIT_OUT_EN] |=> !out_o) else $error("output not forced low");
	a_disabled_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!ctrl_a_reg[BIT_ENABLE] |=> !run_reg) else $error("run while disabled");
	a_capture_loads: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(mode == M_CAPTURE && act && !wr_cmp_hi) |=> cmp_reg == $past(cnt_reg))
		else $error("capture missed");
	a_flag_sets: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		set_flag |=> flag_reg) else $error("flag not set");
	a_freq_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(mode == M_FREQ && act && !wr_cnt_hi) |=> cnt_reg == 16'h0000)
		else $error("counter not cleared");
	a_periodic_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(mode == M_PERIODIC && !wr_cmp_hi) |=> $stable(cmp_reg)) else $error("edge acted");
	a_events_gated: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!ev_ctrl_reg[BIT_EV_EN] && capture_mode) |-> !set_flag) else $error("ungated event");
	a_init_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(mode != M_SINGLE && mode != M_PWM8 && ctrl_b_reg[BIT_OUT_EN]) [*2]
		|-> out_o == $past(ctrl_b_reg[BIT_OUT_INIT])) else $error("initial level wrong");
	a_sync_restart: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(comp_restart_i && ctrl_a_reg[BIT_SYNC_RST] && !wr_cnt_hi) |=> cnt_reg == 16'h0000)
		else $error("no restart with companion");
	a_shot_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(mode == M_SINGLE && ctrl_b_reg[BIT_OUT_EN] && run_reg) |=> out_o)
		else $error("shot output low while running");
	c_capture: cover property (@(posedge clk_i) mode == M_CAPTURE && act);
	c_freqpw: cover property (@(posedge clk_i) mode == M_FREQPW && do_stop);
	c_single: cover property (@(posedge clk_i) mode == M_SINGLE && do_start);
	c_pwidth: cover property (@(posedge clk_i) mode == M_PWIDTH && opp);
	c_sync: cover property (@(posedge clk_i) comp_restart_i && ctrl_a_reg[BIT_SYNC_RST]);

endmodule : etc_event_timer

// >>> etc_partner.sv
`timescale 1ns/100ps
// ----
// far side: event channel source and companion timer
// ----
module etc_partner (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	output logic      ev_o,
	output logic      tick_o,
	output logic      restart_o
);
	logic       run_reg;
	logic [4:0] div_reg;

	initial begin
		ev_o    = 1'b0;
		run_reg = 1'b0;
	end
	// companion counts only when asked, so its clock stands still otherwise
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			div_reg <= 5'h00;
		end else if (run_reg) begin
			div_reg <= div_reg + 5'h01;
		end
	end
	assign tick_o    = run_reg;
	assign restart_o = run_reg && (div_reg == 5'h1F); // restarts every 32 cycles
	// event level moves just after an edge, like a routed channel
	task automatic set_ev(input logic v);
		@(posedge clk_i);
		ev_o <= v;
	endtask : set_ev
	task automatic set_run(input logic v);
		@(posedge clk_i);
		run_reg <= v;
	endtask : set_run
endmodule : etc_partner

// >>> event_timer_capture_config_test.sv
`timescale 1ns/100ps
module event_timer_capture_config_test
	import etc_pkg::*;
;
	logic        clk_i, rst_b_i, wr_i, rd_i, standby_i, debug_halt_i;
	logic [3:0]  addr_i;
	logic [7:0]  wdata_i, rdata_o, d;
	logic        out_o, irq_o, event_o, ev, tick, rst_ev;
	logic [15:0] v, u, evs;
	int          mismatches, compares;

	etc_event_timer dut_u (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_i(ev),
		.comp_tick_i(tick), .comp_restart_i(rst_ev), .standby_i(standby_i),
		.debug_halt_i(debug_halt_i), .out_o(out_o), .irq_o(irq_o), .event_o(event_o)
	);
	etc_partner ptn_u (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .ev_o(ev), .tick_o(tick), .restart_o(rst_ev)
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// counts strobes on the event output so the flag source is seen from outside
	always @(posedge clk_i) begin
		if (!rst_b_i)
			evs <= 16'h0000;
		else if (event_o === 1'b1)
			evs <= evs + 16'h0001;
	end
	// ----
	// checking and bus helpers
	// ----
	task automatic summarize();
		if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// counts drift by a cycle or two with bus timing, so some checks take a span
	task automatic chk_in(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
		compares++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
		end
	endtask : chk_in
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [7:0] x);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= x;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] x);
		@(posedge clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 x = rdata_o;
	endtask : rd
	// low byte first on both paths so the shared latch pairs them
	task automatic wr16(input logic [3:0] a, input logic [15:0] x);
		wr(a, x[7:0]);
		wr(a + 4'h1, x[15:8]);
	endtask : wr16
	task automatic rd16(input logic [3:0] a, output logic [15:0] x);
		rd(a, x[7:0]);
		rd(a + 4'h1, x[15:8]);
	endtask : rd16
	task automatic ev_to(input logic x);
		ptn_u.set_ev(x);
		cyc(6);
	endtask : ev_to
	task automatic flag(input logic [7:0] e);
		rd(ADDR_INT_FLAG, d);
		chk(d, e);
	endtask : flag
	// count for a fixed span from zero, then freeze by disabling
	task automatic run(input logic [7:0] c, input logic [15:0] lo, input logic [15:0] hi);
		wr16(ADDR_CNT_LO, 16'h0000);
		wr(ADDR_CTRL_A, c);
		cyc(20);
		wr(ADDR_CTRL_A, 8'h00);
		rd16(ADDR_CNT_LO, v);
		chk_in(v, lo, hi);
	endtask : run
	// ----
	// scenarios
	// ----
	task automatic t_regs();
		for (int a = 0; a < 16; a++) begin
			rd(a[3:0], d);
			chk(d, 8'h00);
		end
		wr(ADDR_CTRL_A, 8'hFF);
		rd(ADDR_CTRL_A, d);
		chk(d, 8'h57);
		wr(4'h2, 8'hFF);
		rd(4'h2, d);
		chk(d, 8'h00);
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_CTRL_B, m[7:0]);
			rd(ADDR_CTRL_B, d);
			chk(d, m[15:0]);
		end
		wr16(ADDR_CMP_LO, 16'h1234);
		rd16(ADDR_CMP_LO, v);
		chk(v, 16'h1234);
		rd(ADDR_LATCH, d);
		chk(d, 8'h12);
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_CTRL_B, 8'h00);
	endtask : t_regs
	task automatic t_count();
		run(8'h00, 16'h0000, 16'h0000);
		run(8'h01, 16'h0014, 16'h001A);
		run(8'h03, 16'h0009, 16'h000E);
		run(8'h05, 16'h0000, 16'h0000);
		standby_i <= 1'b1;
		run(8'h01, 16'h0000, 16'h0000);
		run(8'h41, 16'h0014, 16'h001A);
		standby_i <= 1'b0;
	endtask : t_count
	task automatic t_capture();
		wr(ADDR_CTRL_B, 8'h02);
		wr(ADDR_INT_EN, 8'h01);
		wr(ADDR_CTRL_A, 8'h01);
		ev_to(1'b1);
		flag(8'h00);
		ev_to(1'b0);
		wr(ADDR_EV_CTRL, 8'h01);
		ev_to(1'b1);
		flag(8'h01);
		chk(irq_o, 1'b1);
		chk(evs, 16'h0001);
		rd(ADDR_CMP_LO, d);
		flag(8'h00);
		ev_to(1'b0);
		flag(8'h00);
		wr(ADDR_EV_CTRL, 8'h11);
		ev_to(1'b1);
		flag(8'h00);
		ev_to(1'b0);
		flag(8'h01);
		wr(ADDR_INT_FLAG, 8'h01);
		flag(8'h00);
		wr(ADDR_EV_CTRL, 8'h01);
		wr(ADDR_CTRL_B, 8'h00);
		wr16(ADDR_CNT_LO, 16'h0000);
		ev_to(1'b1);
		ev_to(1'b0);
		flag(8'h00);
	endtask : t_capture
	task automatic t_meas();
		wr(ADDR_CTRL_B, 8'h03);
		wr16(ADDR_CNT_LO, 16'h8000);
		ev_to(1'b1);
		flag(8'h01);
		rd16(ADDR_CNT_LO, v);
		chk_in(v, 16'h0000, 16'h0020);
		rd16(ADDR_CMP_LO, u);
		chk_in(u, 16'h8000, 16'h8010);
		wr(ADDR_INT_FLAG, 8'h01);
		ev_to(1'b0);
		wr(ADDR_CTRL_B, 8'h04);
		ev_to(1'b1);
		flag(8'h00);
		ev_to(1'b0);
		flag(8'h01);
		wr(ADDR_INT_FLAG, 8'h01);
		wr(ADDR_CTRL_B, 8'h05);
		ev_to(1'b1);
		ev_to(1'b0);
		flag(8'h00);
		ev_to(1'b1);
		flag(8'h01);
		rd16(ADDR_CNT_LO, u);
		rd16(ADDR_CNT_LO, v);
		chk(v, u);
		wr(ADDR_INT_FLAG, 8'h01);
		ev_to(1'b0);
	endtask : t_meas
	task automatic t_out();
		wr(ADDR_CTRL_B, 8'h20);
		cyc(2);
		chk(out_o, 1'b0);
		wr(ADDR_CTRL_B, 8'h30);
		cyc(2);
		chk(out_o, 1'b1);
		wr(ADDR_CTRL_B, 8'h10);
		cyc(2);
		chk(out_o, 1'b0);
		// counter parked at top so enabling alone does not fire the shot
		wr(ADDR_CTRL_A, 8'h00);
		wr16(ADDR_CMP_LO, 16'h0040);
		for (int i = 0; i < 2; i++) begin
			wr16(ADDR_CNT_LO, 16'h0040);
			wr(ADDR_CTRL_B, i ? 8'h56 : 8'h16);
			wr(ADDR_CTRL_A, 8'h01);
			cyc(4);
			chk(out_o, 1'b0);
			// the asynchronous form rises on the start edge, one cycle before the synchronous form
			ptn_u.set_ev(1'b1);
			cyc(4);
			chk(out_o, i[15:0]);
			cyc(2);
			chk(out_o, 1'b1);
			cyc(80);
			chk(out_o, 1'b0);
			ev_to(1'b0);
			wr(ADDR_CTRL_A, 8'h00);
		end
	endtask : t_out
	// timeout runs between edges and ends at top; pwm is high 2 of every 4 cycles
	task automatic t_modes();
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_CTRL_B, 8'h01);
		wr16(ADDR_CMP_LO, 16'h0010);
		wr(ADDR_INT_FLAG, 8'h01);
		wr(ADDR_CTRL_A, 8'h01);
		ev_to(1'b1);
		rd(ADDR_RUN_ST, d);
		chk(d, 8'h01);
		ev_to(1'b0);
		rd(ADDR_RUN_ST, d);
		chk(d, 8'h00);
		flag(8'h00);
		ev_to(1'b1);
		cyc(20);
		flag(8'h01);
		rd(ADDR_RUN_ST, d);
		chk(d, 8'h00);
		ev_to(1'b0);
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_CTRL_B, 8'h17);
		wr16(ADDR_CMP_LO, 16'h0203);
		wr16(ADDR_CNT_LO, 16'h0000);
		wr(ADDR_CTRL_A, 8'h01);
		cyc(4);
		u = 16'h0000;
		repeat (40) begin
			@(posedge clk_i);
			if (out_o === 1'b1)
				u = u + 16'h0001;
		end
		chk(u, 16'h0014);
		wr(ADDR_CTRL_A, 8'h00);
	endtask : t_modes
	task automatic t_sync_filt();
		wr(ADDR_CTRL_B, 8'h00);
		wr16(ADDR_CMP_LO, 16'hFFFF);
		wr16(ADDR_CNT_LO, 16'h0000);
		ptn_u.set_run(1'b1);
		wr(ADDR_CTRL_A, 8'h11);
		cyc(200);
		rd16(ADDR_CNT_LO, v);
		chk_in(v, 16'h0000, 16'h0024);
		ptn_u.set_run(1'b0);
		wr(ADDR_CTRL_B, 8'h02);
		wr(ADDR_CTRL_A, 8'h01);
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_INT_FLAG, 8'h01);
			wr(ADDR_EV_CTRL, i ? 8'h01 : 8'h41);
			ptn_u.set_ev(1'b1);
			@(posedge clk_i);
			ptn_u.set_ev(1'b0);
			cyc(12);
			flag(i[7:0]);
		end
	endtask : t_sync_filt
	// ----
	// main sequence and watchdog
	// ----
	initial begin
		rst_b_i      = 1'b0;
		wr_i         = 1'b0;
		rd_i         = 1'b0;
		addr_i       = 4'h0;
		wdata_i      = 8'h00;
		standby_i    = 1'b0;
		debug_halt_i = 1'b0;
		mismatches   = 0;
		compares     = 0;
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_regs();
		t_count();
		t_capture();
		t_meas();
		t_out();
		t_modes();
		t_sync_filt();
		summarize();
	end
	// the whole run needs about 1100 cycles; ten thousand means a hang
	initial begin
		#100000;
		mismatches++;
		summarize();
	end
endmodule : event_timer_capture_config_test
